// [hdl/exc_route_pkg.sv]
package exc_route_pkg;

  // Register map.
  localparam logic [1:0] ROUTE_REG_INDEX = 2'h3;
  localparam logic [7:0] ROUTE_REG_RESET = 8'h00;
  localparam int         SRC_ONE_MSB     = 7;
  localparam int         SRC_ONE_LSB     = 5;
  localparam int         SRC_TWO_MSB     = 4;
  localparam int         SRC_TWO_LSB     = 2;
  localparam logic [2:0] ROUTE_OFF       = 3'h0;
  localparam logic [2:0] ROUTE_RESERVED  = 3'h7;
  localparam int         ROUTE_TARGETS   = 6;

  // Command opcodes live in the upper nibble, register index in bits 3:2.
  localparam logic [3:0] CMD_WRITE_OP = 4'h4;
  localparam logic [3:0] CMD_READ_OP  = 4'h2;

  // Upper address bits; value is arbitrary.
  localparam logic [2:0] ADDR_BASE_HI = 3'h4;

  // Bit counter value that marks a full byte.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Target protocol states.
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RDATA_ACK = 9'h100
  } tgt_state_t;

endpackage

// [hdl/exc_route_cfg.sv]
`timescale 1ns/100ps
`default_nettype none

module exc_route_cfg
  import exc_route_pkg::*;
(
  // Clock and reset.
  input  wire  logic       sys_clk,
  input  wire  logic       rst,
  // Two-wire bus pins; the clock pin is input only.
  input  wire  logic       scl_in,
  input  wire  logic       sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Address straps, each a two-bit connection code.
  input  wire  logic [1:0] address_select_pin_0,
  input  wire  logic [1:0] address_select_pin_1,
  // Data-ready request from the converter core and its open-drain pin.
  input  wire  logic       result_ready,
  output logic             conversion_ready_out,
  output logic             conversion_ready_oe,
  // Routing to the analog switches.
  output logic [2:0]       source_one_route_sel,
  output logic [2:0]       source_two_route_sel,
  output logic [5:0]       excitation_source_one,
  output logic [5:0]       excitation_source_two
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic [3:0] strap_meta_reg;
  logic [3:0] strap_reg;
  tgt_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] route_reg;
  logic       rd_pending_reg;
  logic [1:0] rd_index_reg;
  logic       wr_pending_reg;
  logic [1:0] wr_index_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [6:0] own_addr;
  logic [7:0] route_read;

  // Two-flop synchronisers for the bus pins.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end

  // Previous synchronised levels for edge detection.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // Bus events decoded from the synchronised pins.
  assign scl_rise   = scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall   = ~scl_sync_reg[1] & scl_prev_reg;
  assign start_cond = scl_sync_reg[1] & scl_prev_reg & ~sda_sync_reg[1] & sda_prev_reg;
  assign stop_cond  = scl_sync_reg[1] & scl_prev_reg & sda_sync_reg[1] & ~sda_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Straps pass two flops; each pin's four connections give four codes.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_meta_reg <= 4'h0;
      strap_reg      <= 4'h0;
    end else begin
      strap_meta_reg <= {address_select_pin_1, address_select_pin_0};
      strap_reg      <= strap_meta_reg;
    end
  end

  assign own_addr = {ADDR_BASE_HI, strap_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Protocol sequencer: samples and shifts on clock rise, drives the data pin on clock fall.
  // target protocol engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      sda_oe         <= 1'b0;
      rd_pending_reg <= 1'b0;
      rd_index_reg   <= 2'h0;
      wr_pending_reg <= 1'b0;
      wr_index_reg   <= 2'h0;
    end else if (start_cond) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end else if (stop_cond) begin
      state_reg      <= ST_IDLE;
      sda_oe         <= 1'b0;
      wr_pending_reg <= 1'b0;
    end else if (scl_rise) begin
      if (state_reg == ST_ADDR || state_reg == ST_CMD || state_reg == ST_WDATA || state_reg == ST_RDATA) begin
        shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            if (shift_reg[7:1] == own_addr) begin
              state_reg <= ST_ADDR_ACK;
              sda_oe    <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt_reg <= 4'h0;
          if (shift_reg[0]) begin
            state_reg      <= ST_RDATA;
            tx_reg         <= (rd_pending_reg && rd_index_reg == ROUTE_REG_INDEX) ? route_read : 8'h00;
            sda_oe         <= ~((rd_pending_reg && rd_index_reg == ROUTE_REG_INDEX) ? route_read[7] : 1'b0);
            rd_pending_reg <= 1'b0;
          end else begin
            state_reg <= ST_CMD;
            sda_oe    <= 1'b0;
          end
        end
        ST_CMD: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            state_reg <= ST_CMD_ACK;
            sda_oe    <= 1'b1;
          end
        end
        ST_CMD_ACK: begin
          sda_oe      <= 1'b0;
          bit_cnt_reg <= 4'h0;
          if (shift_reg[7:4] == CMD_WRITE_OP) begin
            state_reg      <= ST_WDATA;
            wr_pending_reg <= 1'b1;
            wr_index_reg   <= shift_reg[3:2];
          end else begin
            state_reg      <= ST_IDLE;
            rd_pending_reg <= (shift_reg[7:4] == CMD_READ_OP);
            rd_index_reg   <= shift_reg[3:2];
          end
        end
        ST_WDATA: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            state_reg <= ST_WDATA_ACK;
            sda_oe    <= 1'b1;
          end
        end
        ST_WDATA_ACK: begin
          state_reg      <= ST_IDLE;
          sda_oe         <= 1'b0;
          wr_pending_reg <= 1'b0;
        end
        ST_RDATA: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            state_reg <= ST_RDATA_ACK;
            sda_oe    <= 1'b0;
          end else begin
            sda_oe <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
          end
        end
        ST_RDATA_ACK: begin
          state_reg <= ST_IDLE;
          sda_oe    <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe    <= 1'b0;
        end
      endcase
    end
  end

  // no clock driver
  // The data pin only ever pulls low; the clock pin has no output at all.
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Routing register, committed when the data byte is acknowledged.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      route_reg <= ROUTE_REG_RESET;
    end else if (scl_fall && !start_cond && !stop_cond && state_reg == ST_WDATA
                 && bit_cnt_reg == BYTE_BITS && wr_pending_reg && wr_index_reg == ROUTE_REG_INDEX) begin
      route_reg <= {shift_reg[SRC_ONE_MSB:SRC_TWO_LSB], 2'h0};
    end
  end

  assign route_read = {route_reg[SRC_ONE_MSB:SRC_TWO_LSB], 2'h0};

  // Field outputs straight from the register.
  assign source_one_route_sel = route_reg[SRC_ONE_MSB:SRC_ONE_LSB];
  assign source_two_route_sel = route_reg[SRC_TWO_MSB:SRC_TWO_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Switch enables; code 111 closes nothing, keeping a stray write harmless.
  genvar g;
  generate
    for (g = 0; g < ROUTE_TARGETS; g++) begin : g_route
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          excitation_source_one[g] <= 1'b0;
          excitation_source_two[g] <= 1'b0;
        end else begin
          excitation_source_one[g] <= (route_reg[SRC_ONE_MSB:SRC_ONE_LSB] == 3'(g + 1));
          excitation_source_two[g] <= (route_reg[SRC_TWO_MSB:SRC_TWO_LSB] == 3'(g + 1));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain data-ready pin: low while a result waits, released otherwise.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conversion_ready_oe <= 1'b0;
    end else begin
      conversion_ready_oe <= result_ready;
    end
  end

  assign conversion_ready_out = 1'b0;

endmodule

`default_nettype wire

// [bench/exc_route_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module exc_route_monitor (
  // Clock and reset.
  input wire logic       sys_clk,
  input wire logic       rst,
  // Bus and data-ready pins.
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       result_ready,
  input wire logic       conversion_ready_out,
  input wire logic       conversion_ready_oe,
  // Routing outputs.
  input wire logic [2:0] source_one_route_sel,
  input wire logic [2:0] source_two_route_sel,
  input wire logic [5:0] excitation_source_one,
  input wire logic [5:0] excitation_source_two
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Turns a route code into its switch set; the reserved code closes nothing.
  function automatic logic [5:0] hot(input logic [2:0] c);
    hot = (c != 3'h0 && c != 3'h7) ? (6'h01 << (c - 3'h1)) : 6'h00;
  endfunction
  // The bus clock pin has just risen.
  sequence scl_rise_seen;
    $rose(scl_in);
  endsequence
  // Switches follow the fields, data line moves only while the clock is low.
  a_hot_one:
    assert property (1'b1 |=> excitation_source_one == hot($past(source_one_route_sel))) else $error("switch one wrong");
  a_hot_two:
    assert property (1'b1 |=> excitation_source_two == hot($past(source_two_route_sel))) else $error("switch two wrong");
  a_route_commit:
    assert property (!$stable({source_one_route_sel, source_two_route_sel}) |-> sda_oe) else $error("route moved off ack");
  a_scl_high_hold:
    assert property (scl_rise_seen |-> $stable(sda_oe) [*8]) else $error("data moved with clock high");
  a_ready_pull:
    assert property (result_ready |=> conversion_ready_oe) else $error("ready not pulled");
  a_ready_release:
    assert property (!result_ready |=> !conversion_ready_oe) else $error("ready not released");
  a_open_drain:
    assert property (!sda_out && !conversion_ready_out) else $error("pin driven high");
  // Registers clear asynchronously as soon as reset rises, without waiting for a clock edge; the check still looks one edge later.
  a_reset_clear:
    assert property (disable iff (1'b0) rst |=> !sda_oe && !conversion_ready_oe
      && {source_one_route_sel, source_two_route_sel, excitation_source_one, excitation_source_two} == 18'h0)
    else $error("reset left state");
endmodule
bind exc_route_cfg exc_route_monitor mon (.sys_clk, .rst, .scl_in, .sda_out, .sda_oe, .result_ready,
  .conversion_ready_out, .conversion_ready_oe, .source_one_route_sel, .source_two_route_sel,
  .excitation_source_one, .excitation_source_two);
`default_nettype wire

// [bench/bus_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
module bus_ctl
  import exc_route_pkg::*;
(
  // Clock and open-drain bus pins.
  input  wire logic sys_clk,
  input  wire logic sda_in,
  output var logic  scl,
  output var logic  sda_low
);
  // Idle bus: clock high, data released.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One clock phase, kept well above the target's sampling delay.
  task automatic ph();
    repeat (10) @(posedge sys_clk);
  endtask
  // Bit, start and stop levels; bits change data only while the clock is low, start and stop change it while the clock is high.
  task automatic put(input logic b);
    sda_low <= ~b; ph(); scl <= 1'b1; ph(); scl <= 1'b0; ph();
  endtask
  task automatic get(output logic r);
    sda_low <= 1'b0; ph(); scl <= 1'b1; ph(); r = sda_in; scl <= 1'b0; ph();
  endtask
  task automatic start();
    sda_low <= 1'b0; ph(); scl <= 1'b1; ph(); sda_low <= 1'b1; ph(); scl <= 1'b0; ph();
  endtask
  task automatic stop();
    sda_low <= 1'b1; ph(); scl <= 1'b1; ph(); sda_low <= 1'b0; ph();
  endtask
  // Bytes go most significant bit first; reads end with a not-acknowledge.
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) put(b[i]);
    get(n);
    ack = ~n;
  endtask
  task automatic byte_in(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
  endtask
  task automatic write_reg(input logic [6:0] adr, input logic [1:0] idx, input logic [7:0] v, output logic ok);
    logic a0, a1, a2;
    start();
    byte_out({adr, 1'b0}, a0);
    byte_out({CMD_WRITE_OP, idx, 2'h0}, a1);
    byte_out({v[7:2], 2'h0}, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [6:0] adr, input logic [1:0] idx, output logic [7:0] d);
    logic a;
    start();
    byte_out({adr, 1'b0}, a);
    byte_out({CMD_READ_OP, idx, 2'h0}, a);
    start();
    byte_out({adr, 1'b1}, a);
    byte_in(d);
    stop();
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import exc_route_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       result_ready = 1'b0;
  logic [1:0] pin0 = 2'h0;
  logic [1:0] pin1 = 2'h0;
  logic       scl, sda_low, sda_out, sda_oe, rdy_out, rdy_oe;
  logic [2:0] sel_one, sel_two;
  logic [5:0] hot_one, hot_two;
  wire logic  sda_line;
  integer     seed = 33;
  integer     miscompares = 0;
  integer     comparisons = 0;
  // Pulled-up data line; the clock line has no device driver.
  assign sda_line = ~(sda_oe | sda_low);
  always #2 sys_clk = ~sys_clk;
  exc_route_cfg dut (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pin_0(pin0), .address_select_pin_1(pin1), .result_ready(result_ready),
    .conversion_ready_out(rdy_out), .conversion_ready_oe(rdy_oe), .source_one_route_sel(sel_one),
    .source_two_route_sel(sel_two), .excitation_source_one(hot_one), .excitation_source_two(hot_two));
  bus_ctl ctl (.sys_clk(sys_clk), .sda_in(sda_line), .scl(scl), .sda_low(sda_low));
  // Expected switch set and own bus address.
  function automatic logic [7:0] exp_hot(input logic [2:0] c);
    exp_hot = (c >= 3'h1 && c <= 3'h6) ? (8'h01 << (c - 3'h1)) : 8'h00;
  endfunction
  function automatic logic [6:0] own();
    own = {ADDR_BASE_HI, pin1, pin0};
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    logic [7:0] d, r;
    logic       ok;
    logic [2:0] c2;
    pin0 <= 2'($random(seed));
    pin1 <= 2'($random(seed));
    r = 8'($unsigned($random(seed)) % 7);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ctl.read_reg(own(), ROUTE_REG_INDEX, d);
    check("reset_value", ROUTE_REG_RESET, d);
    for (int i = 0; i < 7; i++) begin
      c2 = 3'((i + r) % 7);
      ctl.write_reg(own(), ROUTE_REG_INDEX, {3'(i), c2, 2'($random(seed))}, ok);
      check("write_ack", 8'h01, {7'h0, ok});
      check("sel_one", {5'h0, 3'(i)}, {5'h0, sel_one});
      check("sel_two", {5'h0, c2}, {5'h0, sel_two});
      check("hot_one", exp_hot(3'(i)), {2'h0, hot_one});
      check("hot_two", exp_hot(c2), {2'h0, hot_two});
      ctl.read_reg(own(), ROUTE_REG_INDEX, d);
      check("read_back", {3'(i), c2, 2'h0}, d);
    end
    ctl.write_reg(own(), 2'h2, 8'hfc, ok);
    ctl.read_reg(own(), 2'h2, d);
    check("other_index", 8'h00, d);
    ctl.write_reg(own() ^ 7'h05, ROUTE_REG_INDEX, 8'h24, ok);
    check("foreign_ack", 8'h00, {7'h0, ok});
    ctl.read_reg(own(), ROUTE_REG_INDEX, d);
    check("kept_value", {3'h6, c2, 2'h0}, d);
    result_ready <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("ready_pull", 8'h01, {6'h0, rdy_out, rdy_oe});
    result_ready <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check("ready_free", 8'h00, {6'h0, rdy_out, rdy_oe});
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset_route", 8'h00, {2'h0, sel_one, sel_two});
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    ctl.read_reg(own(), ROUTE_REG_INDEX, d);
    check("reset_again", ROUTE_REG_RESET, d);
    complete_run();
  end
  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
